// >>> rtl/fast_counter_defines.vh
// Constants for the fast pulse counter controller: register indices, field positions,
// counting modes and status bit positions.
// Assumes byte address = 4 * register index on a 32-bit APB bus.
`ifndef FAST_COUNTER_DEFINES_VH
`define FAST_COUNTER_DEFINES_VH

// Register indices; the byte address is four times the index.
`define IDX_CTRL0 8'h25
`define IDX_CUR0 8'h26
`define IDX_PRE0 8'h2A
`define IDX_CTRL1 8'h2F
`define IDX_CUR1 8'h30
`define IDX_PRE1 8'h34
`define IDX_DEFINE 8'h40
`define IDX_APPLY 8'h41
`define IDX_STATUS 8'h42
`define IDX_COUNT0 8'h43
`define IDX_COUNT1 8'h44
`define IDX_EVENT 8'h45
`define IDX_ERROR 8'h46
`define IDX_MODE 8'h47

// Control byte fields.
`define CTL_ENABLE 7
`define CTL_LOAD_CUR 6
`define CTL_LOAD_PRE 5
`define CTL_UPD_DIR 4
`define CTL_DIR_UP 3
`define CTL_QUAD_1X 2
`define CTL_START_LOW 1
`define CTL_RESET_LOW 0

// Define-mode command fields.
`define DEF_CNT_BIT 8

// Status byte bit positions.
`define ST_DIR 5
`define ST_EQ 6
`define ST_GT 7

// Event flag positions within one counter's three-bit group.
`define EV_EQ 0
`define EV_DIR 1
`define EV_XRST 2

// Counting modes.
`define MODE_EXTDIR_LO 4'h3
`define MODE_UPDN_LO 4'h6
`define MODE_QUAD_LO 4'h9
`define MODE_QUAD_HI 4'hB
`define MODE_PTG 4'hC

// Reset values.
`define CTRL_RST 8'h00
`define WORD_RST 32'h00000000

`endif

// >>> rtl/fast_counter_control.v
// Fast pulse counter controller with two counters behind an APB slave.
// Assumes pulse pins are asynchronous to REF_CLK_I and pulse faster than
// half the clock rate never occur; the pulse train input is same-domain logic.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "fast_counter_defines.vh"

module fast_counter_control #(
	parameter NCNT = 2
) (
	input wire REF_CLK_I, // System clock, 100 MHz.
	input wire RST_I, // Synchronous reset, active high.
	input wire PSEL_I, // APB select.
	input wire PENABLE_I, // APB enable.
	input wire PWRITE_I, // APB direction, high for write.
	input wire [9:0] PADDR_I, // APB byte address.
	input wire [31:0] PWDATA_I, // APB write data.
	output reg [31:0] PRDATA_O, // APB read data.
	output wire PREADY_O, // APB ready, always high.
	output reg PSLVERR_O, // APB error for unmapped address.
	input wire [1:0] CNT_A_I, // Clock, up clock or phase A pin per counter.
	input wire [1:0] CNT_B_I, // Direction, down clock or phase B pin per counter.
	input wire [1:0] CNT_RST_I, // External reset pin per counter.
	input wire [1:0] CNT_START_I, // External start pin per counter.
	input wire PTG0_PULSE_I // One-cycle pulse from pulse train generator zero.
);

	wire setup_w;
	wire wr_w;
	wire [7:0] idx_w;
	wire [8*NCNT-1:0] pin_raw_w;
	wire [32*NCNT-1:0] count_w;
	wire [8*NCNT-1:0] status_w;
	wire [3*NCNT-1:0] ev_w;
	wire [5*NCNT-1:0] mode_w;
	wire [NCNT-1:0] def_err_w;
	reg [8*NCNT-1:0] pin_s1_ff;
	reg [8*NCNT-1:0] pin_s2_ff;
	reg err_ff;
	reg [31:0] nxt_rdata;
	reg nxt_slverr;

	// Zero-wait slave: the read word is fetched in the setup cycle.
	assign setup_w = PSEL_I & ~PENABLE_I;
	assign wr_w = PSEL_I & PENABLE_I & PWRITE_I;
	assign idx_w = PADDR_I[9:2];
	assign PREADY_O = 1'b1;

	// Two-flop synchronisers; only the second stage feeds counting logic.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_s1_ff <= {8*NCNT{1'b0}};
			pin_s2_ff <= {8*NCNT{1'b0}};
		end else begin
			pin_s1_ff <= pin_raw_w;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Sticky error for bad or repeated mode definition; a new error beats a clear.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			err_ff <= 1'b0;
		end else begin
			err_ff <= (err_ff & ~(wr_w & (idx_w == `IDX_ERROR) & PWDATA_I[0])) | (|def_err_w);
		end
	end

	genvar i;
	generate
		for (i = 0; i < NCNT; i = i + 1) begin : g_cnt
			localparam [7:0] IX_CTRL = (i == 0) ? `IDX_CTRL0 : `IDX_CTRL1;
			localparam [7:0] IX_CUR = (i == 0) ? `IDX_CUR0 : `IDX_CUR1;
			localparam [7:0] IX_PRE = (i == 0) ? `IDX_PRE0 : `IDX_PRE1;
			reg [7:0] ctrl_ff;
			reg [31:0] new_cur_ff;
			reg [31:0] new_pre_ff;
			reg [3:0] mode_ff;
			reg defined_ff;
			reg en_ff;
			reg dir_ff;
			reg quad1x_ff;
			reg [1:0] pol_ff;
			reg [31:0] count_ff;
			reg [31:0] preset_ff;
			reg load_pend_ff;
			reg xrst_prev_ff;
			reg a_prev_ff;
			reg b_prev_ff;
			reg [2:0] ev_ff;
			reg step;
			reg up;
			wire a;
			wire b;
			wire has_rst;
			wire has_start;
			wire ext_dir;
			wire rst_act;
			wire start_ok;
			wire active;
			wire do_step;
			wire [31:0] nxt_count;
			wire [2:0] ev_set;
			wire [2:0] ev_clr;
			wire apply;
			wire define;
			wire mode_ok;

			assign pin_raw_w[8*i+:8] = {4'h0, CNT_START_I[i], CNT_RST_I[i], CNT_B_I[i], CNT_A_I[i]};
			assign a = pin_s2_ff[8*i];
			assign b = pin_s2_ff[8*i+1];

			// Reset input exists in modes 1,2,4,5,7,8,10,11; start only in 2,5,8,11.
			assign has_rst = (mode_ff <= `MODE_QUAD_HI) && (mode_ff % 3 != 0);
			assign has_start = (mode_ff <= `MODE_QUAD_HI) && (mode_ff % 3 == 2);
			assign ext_dir = (mode_ff >= `MODE_EXTDIR_LO) && (mode_ff <= `MODE_QUAD_HI);
			// Polarity bits invert the pins; zero in both means active high.
			assign rst_act = has_rst & (pin_s2_ff[8*i+2] ^ pol_ff[0]);
			assign start_ok = ~has_start | (pin_s2_ff[8*i+3] ^ pol_ff[1]);
			// A pending load holds the counter off for one cycle.
			assign active = defined_ff & en_ff & ~load_pend_ff;
			assign do_step = active & start_ok & step & ~rst_act;
			assign nxt_count = up ? count_ff + 32'h00000001 : count_ff - 32'h00000001;

			// Step and direction decode per counting mode.
			always @* begin
				step = 1'b0;
				up = dir_ff;
				if (mode_ff < `MODE_EXTDIR_LO) begin
					step = a & ~a_prev_ff;
				end else if (mode_ff < `MODE_UPDN_LO) begin
					step = a & ~a_prev_ff;
					up = b;
				end else if (mode_ff < `MODE_QUAD_LO) begin
					// Simultaneous up and down edges cancel.
					step = (a & ~a_prev_ff) ^ (b & ~b_prev_ff);
					up = a & ~a_prev_ff;
				end else if (mode_ff <= `MODE_QUAD_HI) begin
					if (quad1x_ff) begin
						step = a & ~a_prev_ff;
						up = ~b;
					end else begin
						// A double change is a lost phase and is ignored.
						step = (a ^ a_prev_ff) ^ (b ^ b_prev_ff);
						up = a ^ b_prev_ff;
					end
				end else if (i == 0) begin
					step = PTG0_PULSE_I;
				end
			end

			// Events are raised only while active, so a load cycle raises none.
			assign ev_set[`EV_EQ] = do_step & (nxt_count == preset_ff);
			assign ev_set[`EV_DIR] = do_step & ext_dir & (up != dir_ff);
			assign ev_set[`EV_XRST] = active & rst_act & ~xrst_prev_ff;
			assign ev_clr = (wr_w && idx_w == `IDX_EVENT) ? PWDATA_I[3*i+:3] : 3'h0;
			assign apply = wr_w && (idx_w == `IDX_APPLY) && (PWDATA_I[0] == i);
			assign define = wr_w && (idx_w == `IDX_DEFINE) && (PWDATA_I[`DEF_CNT_BIT] == i);
			assign mode_ok = (PWDATA_I[3:0] <= `MODE_QUAD_HI) ||
				((PWDATA_I[3:0] == `MODE_PTG) && (i == 0));
			assign def_err_w[i] = define & (defined_ff | ~mode_ok);

			// Staged control and values: writing them changes nothing by itself.
			always @(posedge REF_CLK_I) begin
				if (RST_I) begin
					ctrl_ff <= `CTRL_RST;
					new_cur_ff <= `WORD_RST;
					new_pre_ff <= `WORD_RST;
				end else if (wr_w) begin
					if (idx_w == IX_CTRL)
						ctrl_ff <= PWDATA_I[7:0];
					if (idx_w == IX_CUR)
						new_cur_ff <= PWDATA_I;
					if (idx_w == IX_PRE)
						new_pre_ff <= PWDATA_I;
				end
			end

			// Mode definition is accepted once per run.
			always @(posedge REF_CLK_I) begin
				if (RST_I) begin
					mode_ff <= 4'h0;
					defined_ff <= 1'b0;
				end else if (define & ~defined_ff & mode_ok) begin
					mode_ff <= PWDATA_I[3:0];
					defined_ff <= 1'b1;
				end
			end

			// Apply, load and counting.
			always @(posedge REF_CLK_I) begin
				if (RST_I) begin
					en_ff <= 1'b0;
					dir_ff <= 1'b1;
					quad1x_ff <= 1'b0;
					pol_ff <= 2'h0;
					count_ff <= `WORD_RST;
					preset_ff <= `WORD_RST;
					load_pend_ff <= 1'b0;
					xrst_prev_ff <= 1'b0;
					a_prev_ff <= 1'b0;
					b_prev_ff <= 1'b0;
					ev_ff <= 3'h0;
				end else begin
					a_prev_ff <= a;
					b_prev_ff <= b;
					xrst_prev_ff <= rst_act;
					ev_ff <= (ev_ff & ~ev_clr) | ev_set;
					if (load_pend_ff) begin
						count_ff <= new_cur_ff;
						load_pend_ff <= 1'b0;
					end else if (active & rst_act) begin
						count_ff <= `WORD_RST;
					end else if (do_step) begin
						count_ff <= nxt_count;
						if (ext_dir)
							dir_ff <= up;
					end
					// An apply overrides a same-cycle step on the fields it touches.
					if (apply & defined_ff) begin
						en_ff <= ctrl_ff[`CTL_ENABLE];
						quad1x_ff <= ctrl_ff[`CTL_QUAD_1X];
						pol_ff <= ctrl_ff[`CTL_START_LOW:`CTL_RESET_LOW];
						if (ctrl_ff[`CTL_LOAD_CUR])
							load_pend_ff <= 1'b1;
						if (ctrl_ff[`CTL_LOAD_PRE])
							preset_ff <= new_pre_ff;
						if (ctrl_ff[`CTL_UPD_DIR])
							dir_ff <= ctrl_ff[`CTL_DIR_UP];
					end
				end
			end

			assign count_w[32*i+:32] = count_ff;
			assign status_w[8*i+:8] = {($signed(count_ff) > $signed(preset_ff)),
				(count_ff == preset_ff), dir_ff, 5'h00};
			assign ev_w[3*i+:3] = ev_ff;
			assign mode_w[5*i+:5] = {defined_ff, mode_ff};
		end
	endgenerate

	// Read mux; unmapped addresses read zero and answer with an error.
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_slverr = 1'b0;
		case (idx_w)
			`IDX_CTRL0: nxt_rdata = {24'h000000, g_cnt[0].ctrl_ff};
			`IDX_CUR0: nxt_rdata = g_cnt[0].new_cur_ff;
			`IDX_PRE0: nxt_rdata = g_cnt[0].new_pre_ff;
			`IDX_CTRL1: nxt_rdata = {24'h000000, g_cnt[1].ctrl_ff};
			`IDX_CUR1: nxt_rdata = g_cnt[1].new_cur_ff;
			`IDX_PRE1: nxt_rdata = g_cnt[1].new_pre_ff;
			`IDX_DEFINE: nxt_rdata = 32'h00000000;
			`IDX_APPLY: nxt_rdata = 32'h00000000;
			`IDX_STATUS: nxt_rdata = {16'h0000, status_w[15:0]};
			`IDX_COUNT0: nxt_rdata = count_w[31:0];
			`IDX_COUNT1: nxt_rdata = count_w[63:32];
			`IDX_EVENT: nxt_rdata = {26'h0000000, ev_w[5:0]};
			`IDX_ERROR: nxt_rdata = {31'h00000000, err_ff};
			`IDX_MODE: nxt_rdata = {22'h000000, mode_w[9:0]};
			default: nxt_slverr = 1'b1;
		endcase
	end

	// Read data and error are registered at the setup edge and held through access.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else if (setup_w) begin
			PRDATA_O <= PWRITE_I ? 32'h00000000 : nxt_rdata;
			PSLVERR_O <= nxt_slverr;
		end
	end

endmodule // fast_counter_control

// >>> verification/fast_counter_control_checker.sv
// Checker for the APB side of the fast counter controller.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ns
`include "fast_counter_defines.vh"
module fast_counter_control_checker #(
	parameter NCNT = 2
) (
	input wire REF_CLK_I, // Clock.
	input wire RST_I, // Reset.
	input wire PSEL_I, // Select.
	input wire PENABLE_I, // Enable.
	input wire PWRITE_I, // Direction.
	input wire [9:0] PADDR_I, // Address.
	input wire [31:0] PWDATA_I, // Write data.
	input wire [31:0] PRDATA_O, // Read data.
	input wire PREADY_O, // Ready.
	input wire PSLVERR_O // Error.
);
	// Bus phase decode shared by the properties.
	wire [7:0] idx = PADDR_I[9:2];
	wire setup = PSEL_I && !PENABLE_I;
	wire rd = setup && !PWRITE_I;
	wire wacc = PSEL_I && PENABLE_I && PWRITE_I;
	wire bad_def = PWDATA_I[3:0] > 4'hC || (PWDATA_I[8] && PWDATA_I[3:0] == `MODE_PTG);
	wire mapped = idx == `IDX_CTRL0 || idx == `IDX_CUR0 || idx == `IDX_PRE0
		|| idx == `IDX_CTRL1 || idx == `IDX_CUR1 || idx == `IDX_PRE1
		|| (idx >= `IDX_DEFINE && idx <= `IDX_MODE);
	reg [7:0] ctl1_ff;
	reg err_ff;
	// Shadows of the staged control byte and of a refused define, so reads can be judged.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ctl1_ff <= 8'h00;
			err_ff <= 1'h0;
		end else begin
			if (wacc && idx == `IDX_CTRL1)
				ctl1_ff <= PWDATA_I[7:0];
			if (wacc && idx == `IDX_DEFINE && bad_def)
				err_ff <= 1'h1;
			else if (wacc && idx == `IDX_ERROR && PWDATA_I[0])
				err_ff <= 1'h0;
		end
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	property p_rdy; PREADY_O; endproperty
	a_rdy: assert property (p_rdy) else $error("ready dropped");
	property p_unmap; setup && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_map; setup && mapped |=> !PSLVERR_O; endproperty
	a_map: assert property (p_map) else $error("mapped access refused");
	property p_hold; !setup |=> $stable(PRDATA_O) && $stable(PSLVERR_O); endproperty
	a_hold: assert property (p_hold) else $error("read data moved outside setup");
	property p_cmd; rd && (idx == `IDX_DEFINE || idx == `IDX_APPLY) |=> PRDATA_O == 32'h0; endproperty
	a_cmd: assert property (p_cmd) else $error("command register read not zero");
	property p_ctl1; rd && idx == `IDX_CTRL1 |=> PRDATA_O[7:0] == $past(ctl1_ff); endproperty
	a_ctl1: assert property (p_ctl1) else $error("staged control byte lost");
	property p_err; rd && idx == `IDX_ERROR && err_ff |=> PRDATA_O[0]; endproperty
	a_err: assert property (p_err) else $error("refused define not flagged");
	property p_stat; rd && idx == `IDX_STATUS |=> !(&PRDATA_O[7:6]) && !(&PRDATA_O[15:14]);
	endproperty
	a_stat: assert property (p_stat) else $error("equal and greater together");
	c_unmap: cover property (rd && !mapped);
	c_apply: cover property (wacc && idx == `IDX_APPLY);
	c_err: cover property (rd && idx == `IDX_ERROR && err_ff);
endmodule // fast_counter_control_checker

bind fast_counter_control fast_counter_control_checker #(.NCNT(NCNT)) chk (
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));

// >>> verification/pulse_source.sv
// Model of the pulse pins: count or up clocks, direction, external reset, pulse train.
// Assumes the bench calls its tasks; pins change just after rising clock edges.
`timescale 1ns/1ns
module pulse_source (
	input wire clk_i, // Clock.
	output reg [1:0] a_o = 2'h0, // Count or up clock.
	output reg [1:0] b_o = 2'h0, // Direction or down clock.
	output reg [1:0] rst_o = 2'h0, // External reset.
	output reg [1:0] st_o = 2'h0, // External start.
	output reg ptg_o = 1'h0 // Pulse train.
);
	// Each high lasts four cycles and each low at least four, so the synchronisers never miss an edge.
	task pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge clk_i);
			a_o[ch] <= 1'h1;
			repeat (4) @(posedge clk_i);
			a_o[ch] <= 1'h0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	// One-cycle pulses of the internal generator, spaced apart.
	task ptg(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ptg_o <= 1'h1;
			@(posedge clk_i);
			ptg_o <= 1'h0;
			repeat (2) @(posedge clk_i);
		end
	endtask
	// One quadrature state on a channel, held four cycles so the synchronisers see it.
	task ab(input int ch, input av, input bv);
		@(posedge clk_i);
		a_o[ch] <= av;
		b_o[ch] <= bv;
		repeat (4) @(posedge clk_i);
	endtask
	// Static level for the external start pins.
	task start(input [1:0] s);
		@(posedge clk_i);
		st_o <= s;
	endtask
	// Static levels for direction and external reset.
	task pins(input [1:0] b, input [1:0] r);
		@(posedge clk_i);
		b_o <= b;
		rst_o <= r;
	endtask
endmodule // pulse_source

// >>> verification/tb_fast_counter_control.sv
// Self-checking bench for the fast counter controller over APB.
// Assumes the pulse source model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "fast_counter_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_fast_counter_control;
	localparam [31:0] ALL = 32'hFFFFFFFF;
	reg clk = 1'h0;
	reg rst = 1'h1;
	reg psel = 1'h0;
	reg pen = 1'h0;
	reg pwr = 1'h0;
	reg [9:0] paddr = 10'h0;
	reg [31:0] pwdata = 32'h0;
	reg [31:0] rdata;
	reg perr;
	wire [31:0] prdata;
	wire pready, pslverr, ptg;
	wire [1:0] a, b, xr, st;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	// Clock and a guard against a hung handshake.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test;
		end
	end
	pulse_source src (.clk_i(clk), .a_o(a), .b_o(b), .rst_o(xr), .st_o(st), .ptg_o(ptg));
	fast_counter_control dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CNT_A_I(a), .CNT_B_I(b), .CNT_RST_I(xr),
		.CNT_START_I(st), .PTG0_PULSE_I(ptg));
	// One APB transfer; the request holds until ready is seen at a rising edge.
	task xfer(input w, input [7:0] i, input [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pen <= 1'h0;
		pwr <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rdata = prdata;
		perr = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task wr(input [7:0] i, input [31:0] d);
		xfer(1'h1, i, d);
	endtask
	task ck(input [7:0] i, input [31:0] m, input [31:0] e);
		xfer(1'h0, i, 32'h0);
		`CHK(rdata & m, e)
	endtask
	// Write a counter's control byte and apply it.
	task cfg(input c, input [7:0] v);
		wr(c ? `IDX_CTRL1 : `IDX_CTRL0, {24'h0, v});
		wr(`IDX_APPLY, {31'h0, c});
	endtask
	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence: counter one in mode 3, then after a reset mode 7, then counter zero in mode 12.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		src.pins(2'h2, 2'h0);
		ck(`IDX_CTRL1, 32'hFF, 32'h0);
		wr(`IDX_CUR1, 32'h5);
		wr(`IDX_PRE1, 32'h7);
		wr(`IDX_CTRL1, 32'hF8);
		wr(`IDX_DEFINE, 32'h103);
		ck(`IDX_COUNT1, ALL, 32'h0);
		wr(`IDX_APPLY, 32'h1);
		ck(`IDX_COUNT1, ALL, 32'h5);
		ck(`IDX_STATUS, 32'hE000, 32'h2000);
		src.pulse(1, 2);
		ck(`IDX_COUNT1, ALL, 32'h7);
		ck(`IDX_STATUS, 32'hE000, 32'h6000);
		ck(`IDX_EVENT, 32'h38, 32'h08);
		wr(`IDX_EVENT, 32'h8);
		src.pins(2'h0, 2'h0);
		src.pulse(1, 1);
		ck(`IDX_COUNT1, ALL, 32'h6);
		ck(`IDX_EVENT, 32'h38, 32'h10);
		wr(`IDX_DEFINE, 32'h104);
		ck(`IDX_ERROR, 32'h1, 32'h1);
		ck(`IDX_MODE, 32'h3E0, 32'h260);
		wr(`IDX_CUR1, 32'h64);
		cfg(1'h1, 8'hC0);
		ck(`IDX_COUNT1, ALL, 32'h64);
		ck(`IDX_STATUS, 32'hE000, 32'h8000);
		wr(`IDX_PRE1, 32'h65);
		cfg(1'h1, 8'hA0);
		ck(`IDX_COUNT1, ALL, 32'h64);
		ck(`IDX_STATUS, 32'hE000, 32'h0);
		src.pins(2'h2, 2'h0);
		src.pulse(1, 1);
		ck(`IDX_COUNT1, ALL, 32'h65);
		cfg(1'h1, 8'h00);
		src.pulse(1, 2);
		ck(`IDX_COUNT1, ALL, 32'h65);
		ck(8'hFF, ALL, 32'h0);
		`CHK(perr, 1'h1)
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		src.pins(2'h0, 2'h0);
		wr(`IDX_DEFINE, 32'h10C);
		ck(`IDX_ERROR, 32'h1, 32'h1);
		wr(`IDX_CUR1, 32'h9);
		wr(`IDX_DEFINE, 32'h107);
		cfg(1'h1, 8'hF8);
		src.pulse(1, 1);
		ck(`IDX_COUNT1, ALL, 32'hA);
		src.pins(2'h0, 2'h2);
		repeat (6) @(posedge clk);
		src.pins(2'h0, 2'h0);
		ck(`IDX_COUNT1, ALL, 32'h0);
		ck(`IDX_EVENT, 32'h20, 32'h20);
		wr(`IDX_PRE0, 32'h3);
		wr(`IDX_DEFINE, 32'h00C);
		cfg(1'h0, 8'hF8);
		src.ptg(3);
		ck(`IDX_COUNT0, ALL, 32'h3);
		ck(`IDX_EVENT, 32'h1, 32'h1);
		cfg(1'h0, 8'h90);
		src.ptg(1);
		ck(`IDX_COUNT0, ALL, 32'h2);
		cfg(1'h0, 8'h98);
		src.ptg(2);
		ck(`IDX_COUNT0, ALL, 32'h4);
		// Third run: counter one in quadrature mode 11, gated by the start pin.
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		src.ab(1, 1'h0, 1'h0);
		src.start(2'h0);
		wr(`IDX_CUR1, 32'h0);
		wr(`IDX_PRE1, 32'h4);
		wr(`IDX_DEFINE, 32'h10B);
		cfg(1'h1, 8'hF8);
		src.ab(1, 1'h1, 1'h0);
		ck(`IDX_COUNT1, ALL, 32'h0);
		src.start(2'h2);
		src.ab(1, 1'h1, 1'h1);
		src.ab(1, 1'h0, 1'h1);
		src.ab(1, 1'h0, 1'h0);
		ck(`IDX_COUNT1, ALL, 32'h3);
		src.ab(1, 1'h1, 1'h0);
		ck(`IDX_EVENT, 32'h8, 32'h8);
		src.ab(1, 1'h0, 1'h0);
		ck(`IDX_COUNT1, ALL, 32'h3);
		ck(`IDX_EVENT, 32'h10, 32'h10);
		cfg(1'h1, 8'hFC);
		src.ab(1, 1'h1, 1'h0);
		src.ab(1, 1'h1, 1'h1);
		src.ab(1, 1'h0, 1'h1);
		src.ab(1, 1'h0, 1'h0);
		src.ab(1, 1'h1, 1'h0);
		ck(`IDX_COUNT1, ALL, 32'h2);
		end_of_test;
	end
endmodule // tb_fast_counter_control
